// >>> rtl/nseh_cfg.svh
`ifndef NSEH_CFG_SVH
`define NSEH_CFG_SVH
// ==========================================================
// Object dictionary indexes and subindexes
`define NSEH_IDX_ERR_BEHAV 16'h1029
`define NSEH_IDX_PROD      16'h2500
`define NSEH_IDX_DO_MODE   16'h6206
`define NSEH_IDX_DO_VAL    16'h6207
`define NSEH_IDX_AO_MODE   16'h6443
`define NSEH_IDX_AO_VAL    16'h6444
`define NSEH_SUB_COUNT     8'h00
`define NSEH_SUB_COMM      8'h01
`define NSEH_SUB_OUT_ERR   8'h02
`define NSEH_SUB_IN_ERR    8'h03
`define NSEH_SUB_MFG       8'h02
`define NSEH_SUB_CAL       8'h03
`define NSEH_PROD_SUBS     8'h03
`define NSEH_BEHAV_SUBS    8'h03
// ==========================================================
// Reaction codes and reset values
`define NSEH_REACT_PREOP   8'h00
`define NSEH_REACT_KEEP    8'h01
`define NSEH_REACT_STOP    8'h02
`define NSEH_REACT_RESET   8'h00
`define NSEH_MODE_RESET    8'h00
`define NSEH_VAL_RESET     8'h00
`define NSEH_AO_VAL_RESET  32'h0000_0000
`define NSEH_AO_MODE_ON    8'h01
`define NSEH_MFG_DATE      32'h0101_2000
`define NSEH_CAL_DATE      32'h0101_2000
// ==========================================================
// Sizes and field positions
`define NSEH_DO_BYTES      3
`define NSEH_DO_SUBS       8'h03
`define NSEH_AO_NUM        2
`define NSEH_AO_SUBS       8'h02
`define NSEH_LAMP_RSVD     5
// ==========================================================
// Network commands from the master
`define NSEH_NMT_START     2'h1
`define NSEH_NMT_STOP      2'h2
`define NSEH_NMT_PREOP     2'h3
// ==========================================================
// Indicator timing
`define NSEH_CLK_KHZ       20000
`define NSEH_FAST_MS       50
`define NSEH_FLASH_MS      200
`define NSEH_OFF_MS        1000
`define NSEH_FAST_CYC      (`NSEH_FAST_MS * `NSEH_CLK_KHZ)
`define NSEH_STEP_TICKS    (`NSEH_FLASH_MS / `NSEH_FAST_MS)
`define NSEH_OFF_STEPS     (`NSEH_OFF_MS / `NSEH_FLASH_MS)
`define NSEH_SF_STEPS      (1 + `NSEH_OFF_STEPS)
`define NSEH_DF_STEPS      (3 + `NSEH_OFF_STEPS)
`endif

// >>> rtl/nseh_pkg.sv
package nseh_pkg;
   // ==========================================================
   // Network state, Gray along preop -> operational -> stopped
   typedef enum logic [1:0] {
      NSEH_PREOP   = 2'b00,
      NSEH_OPER    = 2'b01,
      NSEH_STOPPED = 2'b11
   } nseh_nmt_type;

   // ==========================================================
   // Pattern generator state
   typedef struct packed {
      logic [19:0] tick_cnt;
      logic [1:0]  sub_cnt;
      logic [2:0]  sf_step;
      logic [3:0]  df_step;
      logic        fast;
      logic        blink;
      logic        single;
      logic        double;
   } nseh_pat_type;

   // ==========================================================
   // Top-level state
   typedef struct packed {
      nseh_nmt_type     nmt;
      logic             err_prev;
      logic [7:0]       react;
      logic [23:0]      do_mode;
      logic [23:0]      do_val;
      logic [23:0]      do_out;
      logic [1:0][7:0]  ao_mode;
      logic [1:0][31:0] ao_val;
      logic [1:0][15:0] ao_out;
      logic             run_led;
      logic             err_led;
      logic [7:0]       lamps;
      logic             od_ack;
      logic             od_abort;
      logic [31:0]      od_rdata;
   } nseh_state_type;
endpackage

// >>> rtl/nseh_pattern_gen.sv
`timescale 1ns/100ps
`include "nseh_cfg.svh"
module nseh_pattern_gen
   import nseh_pkg::*;
#(
   parameter int TICK_CYC = `NSEH_FAST_CYC
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic srst,
   // Patterns
   output logic      fast_o,
   output logic      blink_o,
   output logic      single_o,
   output logic      double_o
);
   nseh_pat_type pat_reg;
   nseh_pat_type pat_next;
   logic         tick;
   logic         step;

   // ==========================================================
   // One divider feeds every pattern so they stay in phase
   always_comb begin
      pat_next = pat_reg;
      tick = (pat_reg.tick_cnt == 20'(TICK_CYC - 1));
      step = tick && (pat_reg.sub_cnt == 2'(`NSEH_STEP_TICKS - 1));
      pat_next.tick_cnt = tick ? 20'h0_0000 : pat_reg.tick_cnt + 20'h0_0001;
      if (tick) begin
         pat_next.sub_cnt = step ? 2'h0 : pat_reg.sub_cnt + 2'h1;
         pat_next.fast    = ~pat_reg.fast;
      end
      if (step) begin
         pat_next.blink   = ~pat_reg.blink;
         pat_next.sf_step = (pat_reg.sf_step == 3'(`NSEH_SF_STEPS - 1))
                            ? 3'h0 : pat_reg.sf_step + 3'h1;
         pat_next.df_step = (pat_reg.df_step == 4'(`NSEH_DF_STEPS - 1))
                            ? 4'h0 : pat_reg.df_step + 4'h1;
      end
      pat_next.single = (pat_next.sf_step == 3'h0);
      pat_next.double = (pat_next.df_step == 4'h0) ||
                        (pat_next.df_step == 4'h2);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pat_reg <= '0;
      end else begin
         pat_reg <= pat_next;
      end
   end

   assign fast_o   = pat_reg.fast;
   assign blink_o  = pat_reg.blink;
   assign single_o = pat_reg.single;
   assign double_o = pat_reg.double;
endmodule

// >>> rtl/nseh_top.sv
`timescale 1ns/100ps
`include "nseh_cfg.svh"
module nseh_top
   import nseh_pkg::*;
#(
   parameter int          TICK_CYC = `NSEH_FAST_CYC,
   // Production dates, arbitrary values
   parameter logic [31:0] MFG_DATE = `NSEH_MFG_DATE,
   parameter logic [31:0] CAL_DATE = `NSEH_CAL_DATE
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // Object dictionary access
   input  wire logic        od_req,
   input  wire logic        od_we,
   input  wire logic [15:0] od_index,
   input  wire logic [7:0]  od_sub,
   input  wire logic [31:0] od_wdata,
   output logic             od_ack,
   output logic             od_abort,
   output logic [31:0]      od_rdata,
   // Network management from the master
   input  wire logic        nmt_cmd_valid,
   input  wire logic [1:0]  nmt_cmd,
   output logic [1:0]       nmt_state,
   // Controller and node status
   input  wire logic        warn_limit,
   input  wire logic        bus_off,
   input  wire logic        guard_fail,
   input  wire logic        lss_active,
   input  wire logic        cfg_invalid,
   // Fault display
   input  wire logic        extended_mode,
   input  wire logic [7:0]  fault_flags,
   input  wire logic [7:0]  din_levels,
   output logic [7:0]       input_indicator_lamp,
   output logic             run_led,
   output logic             err_led,
   // Process output data
   input  wire logic        dout_wr,
   input  wire logic [23:0] dout_wdata,
   input  wire logic [1:0]  aout_wr,
   input  wire logic [15:0] aout_wdata,
   output logic [23:0]      digital_output_lines,
   output logic [15:0]      analog_output_zero,
   output logic [15:0]      analog_output_one
);
   nseh_state_type st_reg;
   nseh_state_type st_next;
   logic           pat_fast;
   logic           pat_blink;
   logic           pat_single;
   logic           pat_double;
   logic           comm_err;
   logic           err_event;
   logic [7:0]     fault_shown;

   // ==========================================================
   // Shared indicator patterns
   nseh_pattern_gen #(
      .TICK_CYC (TICK_CYC)
   ) u_pat (
      .clk      (clk),
      .srst     (srst),
      .fast_o   (pat_fast),
      .blink_o  (pat_blink),
      .single_o (pat_single),
      .double_o (pat_double)
   );

   // ==========================================================
   // Helpers
   function automatic logic sub_in(input logic [7:0] sub,
                                   input logic [7:0] last);
      sub_in = (sub != `NSEH_SUB_COUNT) && (sub <= last);
   endfunction

   // Error event is the onset, so a persisting fault acts once
   assign comm_err  = bus_off | guard_fail;
   assign err_event = comm_err & ~st_reg.err_prev;

   // Reserved lamp is forced dark in extended mode
   always_comb begin
      fault_shown = fault_flags;
      fault_shown[`NSEH_LAMP_RSVD] = 1'b0;
   end

   // ==========================================================
   // Next state
   always_comb begin
      st_next          = st_reg;
      st_next.err_prev = comm_err;
      st_next.od_ack   = 1'b0;
      st_next.od_abort = 1'b0;

      // Network state from the master
      if (nmt_cmd_valid) begin
         unique case (nmt_cmd)
            `NSEH_NMT_START: begin
               if (!comm_err) begin
                  st_next.nmt = NSEH_OPER;
               end
            end
            `NSEH_NMT_STOP: st_next.nmt = NSEH_STOPPED;
            `NSEH_NMT_PREOP: st_next.nmt = NSEH_PREOP;
            default: ;
         endcase
      end

      // A preop or stop reaction wins over a command in the same cycle
      if (err_event) begin
         unique case (st_reg.react)
            `NSEH_REACT_PREOP: st_next.nmt = NSEH_PREOP;
            `NSEH_REACT_STOP:  st_next.nmt = NSEH_STOPPED;
            default: ;
         endcase
      end

      // New process data overrides held values; substitution at an error onset in the same cycle wins
      if (dout_wr) begin
         st_next.do_out = dout_wdata;
      end
      for (int a = 0; a < `NSEH_AO_NUM; a++) begin
         if (aout_wr[a]) begin
            st_next.ao_out[a] = aout_wdata;
         end
      end

      // Substitution on the error onset
      if (err_event) begin
         for (int b = 0; b < 24; b++) begin
            if (st_reg.do_mode[b]) begin
               st_next.do_out[b] = st_reg.do_val[b];
            end
         end
         for (int a = 0; a < `NSEH_AO_NUM; a++) begin
            if (st_reg.ao_mode[a] == `NSEH_AO_MODE_ON) begin
               st_next.ao_out[a] = st_reg.ao_val[a][15:0];
            end
         end
      end

      // Object dictionary access, answered next cycle
      if (od_req) begin
         st_next.od_ack   = 1'b1;
         st_next.od_rdata = 32'h0000_0000;
         unique case (od_index)
            `NSEH_IDX_ERR_BEHAV: begin
               if (od_sub == `NSEH_SUB_COMM) begin
                  if (!od_we) begin
                     st_next.od_rdata = {24'h00_0000, st_reg.react};
                  end else if (od_wdata[7:0] <= `NSEH_REACT_STOP &&
                               od_wdata[31:8] == 24'h00_0000) begin
                     st_next.react = od_wdata[7:0];
                  end else begin
                     st_next.od_abort = 1'b1;
                  end
               end else if (od_sub == `NSEH_SUB_COUNT && !od_we) begin
                  st_next.od_rdata = {24'h00_0000, `NSEH_BEHAV_SUBS};
               end else begin
                  st_next.od_abort = 1'b1;
               end
            end
            `NSEH_IDX_PROD: begin
               if (od_we) begin
                  st_next.od_abort = 1'b1;
               end else if (od_sub == `NSEH_SUB_MFG) begin
                  st_next.od_rdata = MFG_DATE;
               end else if (od_sub == `NSEH_SUB_CAL) begin
                  st_next.od_rdata = CAL_DATE;
               end else if (od_sub == `NSEH_SUB_COUNT) begin
                  st_next.od_rdata = {24'h00_0000, `NSEH_PROD_SUBS};
               end else begin
                  st_next.od_abort = 1'b1;
               end
            end
            `NSEH_IDX_DO_MODE,
            `NSEH_IDX_DO_VAL: begin
               if (sub_in(od_sub, `NSEH_DO_SUBS)) begin
                  for (int k = 0; k < `NSEH_DO_BYTES; k++) begin
                     if (od_sub == 8'(k + 1)) begin
                        if (od_index == `NSEH_IDX_DO_MODE) begin
                           st_next.od_rdata[7:0] =
                              st_reg.do_mode[k*8 +: 8];
                           if (od_we) begin
                              st_next.do_mode[k*8 +: 8] =
                                 od_wdata[7:0];
                           end
                        end else begin
                           st_next.od_rdata[7:0] =
                              st_reg.do_val[k*8 +: 8];
                           if (od_we) begin
                              st_next.do_val[k*8 +: 8] =
                                 od_wdata[7:0];
                           end
                        end
                     end
                  end
                  if (od_we) begin
                     st_next.od_rdata = 32'h0000_0000;
                  end
               end else if (od_sub == `NSEH_SUB_COUNT && !od_we) begin
                  st_next.od_rdata = {24'h00_0000, `NSEH_DO_SUBS};
               end else begin
                  st_next.od_abort = 1'b1;
               end
            end
            `NSEH_IDX_AO_MODE,
            `NSEH_IDX_AO_VAL: begin
               if (sub_in(od_sub, `NSEH_AO_SUBS)) begin
                  for (int a = 0; a < `NSEH_AO_NUM; a++) begin
                     if (od_sub == 8'(a + 1)) begin
                        if (od_index == `NSEH_IDX_AO_MODE) begin
                           st_next.od_rdata[7:0] = st_reg.ao_mode[a];
                           if (od_we) begin
                              st_next.ao_mode[a] =
                                 od_wdata[7:0];
                           end
                        end else begin
                           st_next.od_rdata = st_reg.ao_val[a];
                           if (od_we) begin
                              st_next.ao_val[a] = od_wdata;
                           end
                        end
                     end
                  end
                  if (od_we) begin
                     st_next.od_rdata = 32'h0000_0000;
                  end
               end else if (od_sub == `NSEH_SUB_COUNT && !od_we) begin
                  st_next.od_rdata = {24'h00_0000, `NSEH_AO_SUBS};
               end else begin
                  st_next.od_abort = 1'b1;
               end
            end
            default: st_next.od_abort = 1'b1;
         endcase
      end

      // Run lamp by network state
      unique case (st_reg.nmt)
         NSEH_STOPPED: st_next.run_led = pat_single;
         NSEH_PREOP:   st_next.run_led = pat_blink;
         NSEH_OPER:    st_next.run_led = 1'b1;
         default:      st_next.run_led = 1'b0;
      endcase

      // Error lamp, most severe condition first
      if (bus_off) begin
         st_next.err_led = 1'b1;
      end else if (guard_fail) begin
         st_next.err_led = pat_double;
      end else if (warn_limit) begin
         st_next.err_led = pat_single;
      end else begin
         st_next.err_led = 1'b0;
      end

      // Overrides shared by both lamps
      if (cfg_invalid) begin
         st_next.run_led = pat_fast;
         st_next.err_led = pat_fast;
      end else if (lss_active) begin
         st_next.run_led = pat_blink;
         st_next.err_led = ~pat_blink;
      end

      // Input lamps
      st_next.lamps = extended_mode ? fault_shown
                                    : din_levels;
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk) begin
      if (srst) begin
         st_reg          <= '0;
         st_reg.nmt      <= NSEH_PREOP;
         st_reg.react    <= `NSEH_REACT_RESET;
         st_reg.err_prev <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Outputs
   assign od_ack               = st_reg.od_ack;
   assign od_abort             = st_reg.od_abort;
   assign od_rdata             = st_reg.od_rdata;
   assign nmt_state            = st_reg.nmt;
   assign run_led              = st_reg.run_led;
   assign err_led              = st_reg.err_led;
   assign input_indicator_lamp = st_reg.lamps;
   assign digital_output_lines = st_reg.do_out;
   assign analog_output_zero   = st_reg.ao_out[0];
   assign analog_output_one    = st_reg.ao_out[1];
endmodule

// >>> bench/nseh_properties.sv
`timescale 1ns/100ps
// ==========================================================
// Port-level checks of lamps, object access and network state
module nseh_properties (
   // Clock and reset
   input wire logic        clk,
   input wire logic        srst,
   // Requests
   input wire logic        od_req,
   input wire logic        od_we,
   input wire logic [15:0] od_index,
   input wire logic [7:0]  od_sub,
   input wire logic        od_ack,
   input wire logic        od_abort,
   input wire logic        nmt_cmd_valid,
   input wire logic [1:0]  nmt_cmd,
   input wire logic [1:0]  nmt_state,
   // Status and lamps
   input wire logic        warn_limit,
   input wire logic        bus_off,
   input wire logic        guard_fail,
   input wire logic        lss_active,
   input wire logic        cfg_invalid,
   input wire logic        extended_mode,
   input wire logic [7:0]  fault_flags,
   input wire logic [7:0]  din_levels,
   input wire logic [7:0]  input_indicator_lamp,
   input wire logic        run_led,
   input wire logic        err_led
);
   // Held one edge past release, so no check sees the reset cycle
   logic rst_q;
   always_ff @(posedge clk) begin
      rst_q <= srst;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst || rst_q);
   sequence s_quiet;
      !cfg_invalid && !lss_active;
   endsequence
   // Two cycles of operational state, so lamp latency cannot matter
   sequence s_oper;
      (!cfg_invalid && !lss_active && nmt_state == 2'b01) [*2];
   endsequence
   sequence s_fault_held;
      (bus_off || guard_fail) && $past(bus_off || guard_fail);
   endsequence
   a_err_dark_idle: assert property (s_quiet and !bus_off and !guard_fail and !warn_limit |=> !err_led)
      else $error("error lamp lit without fault");
   a_busoff_err_lit: assert property (s_quiet and bus_off |=> err_led)
      else $error("error lamp dark while bus-off");
   a_cfg_sync_blink: assert property (cfg_invalid |=> run_led == err_led)
      else $error("lamps not synchronous on bad config");
   a_lss_alternate: assert property (lss_active && !cfg_invalid |=> run_led != err_led)
      else $error("lamps not alternating during service");
   a_oper_run_lit: assert property (s_oper |=> run_led)
      else $error("run lamp dark while operational");
   a_ext_fault_map: assert property (extended_mode |=> input_indicator_lamp == ($past(fault_flags) & 8'hdf))
      else $error("fault lamps wrong");
   a_din_follow: assert property (!extended_mode |=> input_indicator_lamp == $past(din_levels))
      else $error("input lamps do not follow inputs");
   a_date_readonly: assert property (od_req && od_we && od_index == 16'h2500 |=> od_ack && od_abort)
      else $error("date entry write accepted");
   a_unsup_behav: assert property (od_req && od_we && od_index == 16'h1029 && od_sub != 8'h01 |=> od_abort)
      else $error("unsupported reaction entry written");
   a_start_refused: assert property (nmt_cmd_valid && nmt_cmd == 2'h1 && nmt_state != 2'b01 ##0 s_fault_held |=> nmt_state != 2'b01)
      else $error("start taken with fault present");
endmodule

// >>> bench/nseh_master_model.sv
`timescale 1ns/100ps
// ==========================================================
// Network master: object access and network commands
module nseh_master_model (
   input  wire logic   clk,
   input  wire logic   od_ack,
   output logic        od_req,
   output logic        od_we,
   output logic [15:0] od_index,
   output logic [7:0]  od_sub,
   output logic [31:0] od_wdata,
   output logic        nmt_cmd_valid,
   output logic [1:0]  nmt_cmd
);
   initial begin
      {od_req, od_we, od_index, od_sub, od_wdata} = '0;
      {nmt_cmd_valid, nmt_cmd} = '0;
   end
   task automatic od_xfer(input logic w, input logic [15:0] i,
                          input logic [7:0] s, input logic [31:0] d,
                          output logic to);
      @(posedge clk);
      {od_req, od_we, od_index, od_sub, od_wdata} <= {1'b1, w, i, s, d};
      @(posedge clk);
      // Released lines show the inverse, never a stale copy
      {od_req, od_we, od_index, od_sub, od_wdata} <= {1'b0, ~w, ~i, ~s, ~d};
      to = 1'b1;
      for (int k = 0; k < 3 && to; k++) begin
         #1;
         if (od_ack === 1'b1) to = 1'b0;
         else @(posedge clk);
      end
   endtask
   // Sends any command for one cycle; the bench sends start also while the fault is present
   task automatic nmt(input logic [1:0] c);
      @(posedge clk);
      {nmt_cmd_valid, nmt_cmd} <= {1'b1, c};
      @(posedge clk);
      {nmt_cmd_valid, nmt_cmd} <= {1'b0, ~c};
      #1;
   endtask
endmodule

// >>> bench/tb_node_status_error_handler.sv
`timescale 1ns/100ps
// ==========================================================
// Bench for the status and error-reaction block
module tb_node_status_error_handler;
   import nseh_pkg::*;
   typedef struct packed {
      logic        w;
      logic [15:0] i;
      logic [7:0]  s;
      logic [31:0] d;
      logic        ab;
      logic [31:0] rd;
   } nseh_row_type;
   logic clk, od_req, od_we, od_ack, od_abort, nmt_cmd_valid;
   logic [15:0] od_index;
   logic [7:0] od_sub, input_indicator_lamp;
   logic [31:0] od_wdata, od_rdata;
   logic [1:0] nmt_cmd, nmt_state;
   logic srst = 1'b1, warn_limit = 1'b0, bus_off = 1'b0, guard_fail = 1'b0;
   logic lss_active = 1'b0, cfg_invalid = 1'b0, extended_mode = 1'b0;
   logic [7:0] fault_flags = 8'h00, din_levels = 8'ha5;
   logic dout_wr = 1'b0, run_led, err_led, p;
   logic [23:0] dout_wdata = 24'h0, digital_output_lines;
   logic [1:0] aout_wr = 2'b0;
   logic [15:0] aout_wdata = 16'h0, analog_output_zero, analog_output_one;
   int num_errors = 0, n_tests = 0, c;
   logic [1:0] st [3] = '{2'b00, 2'b01, 2'b11};
   nseh_row_type rows [17] = '{
      {1'b0, 16'h1029, 8'h00, 32'h0, 1'b0, 32'h3},
      {1'b0, 16'h1029, 8'h01, 32'h0, 1'b0, 32'h0},
      {1'b1, 16'h1029, 8'h01, 32'h3, 1'b1, 32'h0},
      {1'b1, 16'h1029, 8'h02, 32'h0, 1'b1, 32'h0},
      {1'b0, 16'h2500, 8'h02, 32'h0, 1'b0, 32'h1702_2009},
      {1'b1, 16'h2500, 8'h02, 32'h0, 1'b1, 32'h0},
      {1'b0, 16'h2500, 8'h02, 32'h0, 1'b0, 32'h1702_2009},
      {1'b0, 16'h2500, 8'h03, 32'h0, 1'b0, 32'h2812_2010},
      {1'b0, 16'h2500, 8'h01, 32'h0, 1'b1, 32'h0},
      {1'b0, 16'h1234, 8'h01, 32'h0, 1'b1, 32'h0},
      {1'b1, 16'h6206, 8'h01, 32'h3, 1'b0, 32'h0},
      {1'b0, 16'h6206, 8'h01, 32'h0, 1'b0, 32'h3},
      {1'b1, 16'h6207, 8'h01, 32'h1, 1'b0, 32'h0},
      {1'b1, 16'h6443, 8'h01, 32'h1, 1'b0, 32'h0},
      {1'b1, 16'h6444, 8'h01, 32'h500, 1'b0, 32'h0},
      {1'b1, 16'h6444, 8'h00, 32'h0, 1'b1, 32'h0},
      {1'b0, 16'h6443, 8'h03, 32'h0, 1'b1, 32'h0}};
   // Short tick: step 16 cycles, fast toggle 4; dates are arbitrary
   nseh_top #(.TICK_CYC(4), .MFG_DATE(32'h1702_2009),
              .CAL_DATE(32'h2812_2010)) i_nseh_top (.*);
   nseh_master_model i_nseh_master_model (.*);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic end_of_test;
      $display("Checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic od(input nseh_row_type r);
      logic to;
      i_nseh_master_model.od_xfer(r.w, r.i, r.s, r.d, to);
      if (to) begin
         chk(1'b0, "no answer");
         end_of_test();
      end else begin
         chk(od_abort === r.ab && (r.ab || od_rdata === r.rd), "od answer");
      end
   endtask
   // Whole periods only, so the count does not depend on phase
   task automatic duty(input logic e, input int n, input int x);
      int k;
      k = 0;
      repeat (2) @(posedge clk);
      repeat (n) begin
         @(posedge clk);
         #1;
         k += int'(e ? err_led : run_led);
      end
      chk(k == x, "lamp duty");
   endtask
   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      duty(1'b0, 192, 96);
      duty(1'b1, 32, 0);
      foreach (rows[k]) od(rows[k]);
      $display("table done");
      for (int r = 0; r < 3; r++) begin
         od({1'b1, 16'h1029, 8'h01, 32'(r), 1'b0, 32'h0});
         i_nseh_master_model.nmt(2'h1);
         @(posedge clk);
         {dout_wr, dout_wdata} <= {1'b1, 24'hfff0f0};
         {aout_wr, aout_wdata} <= {2'b11, 16'h1111};
         @(posedge clk);
         {dout_wr, aout_wr, bus_off} <= 4'b0001;
         @(posedge clk);
         #1;
         chk(nmt_state === st[r], "reaction");
         chk({digital_output_lines, analog_output_zero, analog_output_one} === {24'hfff0f1, 16'h0500, 16'h1111}, "substitute");
         i_nseh_master_model.nmt(2'h1);
         chk(nmt_state === st[r] && digital_output_lines === 24'hfff0f1, "hold");
         @(posedge clk) bus_off <= 1'b0;
         i_nseh_master_model.nmt(2'h1);
         chk(nmt_state === 2'b01, "restart");
      end
      $display("reaction done");
      @(posedge clk) guard_fail <= 1'b1;
      duty(1'b1, 256, 64);
      duty(1'b0, 192, 32);
      @(posedge clk) {guard_fail, warn_limit} <= 2'b01;
      duty(1'b1, 192, 32);
      @(posedge clk) bus_off <= 1'b1;
      duty(1'b1, 24, 24);
      @(posedge clk) cfg_invalid <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      p = run_led;
      c = 0;
      repeat (40) begin
         @(posedge clk);
         #1;
         c += int'(run_led !== p);
         p = run_led;
      end
      chk(c == 10, "fast blink");
      @(posedge clk) {cfg_invalid, lss_active} <= 2'b01;
      din_levels <= 8'h3c;
      repeat (20) @(posedge clk);
      #1;
      chk((run_led ^ err_led) === 1'b1, "alternate");
      chk(input_indicator_lamp === 8'h3c, "input lamps");
      @(posedge clk) lss_active <= 1'b0;
      {extended_mode, fault_flags} <= {1'b1, 8'hff};
      repeat (2) @(posedge clk);
      #1;
      chk(input_indicator_lamp === 8'hdf, "fault lamps");
      $display("lamps done");
      @(posedge clk) srst <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(nmt_state === 2'b00 && digital_output_lines === 24'h0, "reset");
      @(posedge clk) {srst, bus_off, warn_limit, extended_mode} <= 4'b0;
      od({1'b0, 16'h1029, 8'h01, 32'h0, 1'b0, 32'h0});
      $display("reset done");
      end_of_test();
   end
endmodule
bind nseh_top nseh_properties i_nseh_properties (.*);
